// >>> hw/dvt_seq.v
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "dvt_seq_defs.vh"

// Function
// RULE1: three to six phases, strapped phases disabled
// RULE2: single section disabled when its pin strapped
// RULE3: commands to disabled single section rejected
// RULE4: ramp reference toward target at programmed slope
// RULE5: new command mid ramp replaces target
// RULE6: fast 20 mV/us, slow 5 mV/us
// RULE7: mask protection during transition plus delay
// RULE8: total overcurrent during transition latches off
// RULE9: soft start: outputs high impedance, driver off
// RULE10: after first pulse outputs switch, driver on
// RULE11: overvoltage may still turn low side on
// RULE12: memory mode droop gain scaled by quarter
// RULE13: overvoltage raised to 1.8 or 2.4 V
// RULE14: fixed code steps at clock derived ticks
module dvt_seq #(
  parameter CODE_W = 8
) (
  input  wire              mclk,
  input  wire              sys_rst,
  input  wire [5:0]        phase_strap,
  input  wire              single_strap,
  input  wire              first_pulse,
  input  wire [5:0]        pwm_req,
  input  wire              single_section_pwm_out_req,
  input  wire              ov_det,
  input  wire              uv_det,
  input  wire              oc_tot_det,
  output reg  [5:0]        phase_pwm_out,
  output reg  [5:0]        phase_pwm_oe,
  output reg               single_section_pwm_out,
  output reg               single_section_pwm_oe,
  output reg               driver_enable_out,
  output reg  [1:0]        ov_thresh_sel,
  output reg               prot_mask,
  output reg               droop_quarter,
  output reg  [CODE_W-1:0] ref_multi,
  output reg  [CODE_W-1:0] ref_single,
  output reg               irq,
  input  wire [5:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [5:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  localparam ST_OFF   = 4'b0001;
  localparam ST_SOFT  = 4'b0010;
  localparam ST_RUN   = 4'b0100;
  localparam ST_LATCH = 4'b1000;
  localparam integer FAST_I  = `FAST_TICKS;
  localparam integer SLOW_I  = `SLOW_TICKS;
  localparam integer REARM_I = `REARM_TICKS;
  localparam [7:0] FAST_T = FAST_I[7:0];
  localparam [7:0] SLOW_T = SLOW_I[7:0];
  localparam [8:0] REARM_T = REARM_I[8:0];

  reg [CODE_W-1:0] ref_ff [0:1];
  reg [CODE_W-1:0] tgt_ff [0:1];
  reg [7:0]        tick_ff [0:1];
  reg              fast_ff [0:1];
  reg [3:0]        ctrl_ff;
  reg [3:0]        irq_stat_ff;
  reg [3:0]        irq_mask_ff;
  reg [3:0]        state_ff;
  reg              ov_latch_ff;
  reg              strap_done_ff;
  reg [5:0]        phase_en_ff;
  reg              single_dis_ff;
  reg [8:0]        rearm_ff;
  reg              busy_d_ff;
  reg              aw_got_ff;
  reg              w_got_ff;
  reg [5:0]        aw_addr_ff;
  reg [31:0]       w_data_ff;
  reg [3:0]        w_strb_ff;
  reg [3:0]        nxt_state;
  reg [31:0]       nxt_rdata;
  reg              nxt_rmapped;
  reg [3:0]        irq_set;
  integer          s;

  wire busy = (ref_ff[0] != tgt_ff[0]) | (ref_ff[1] != tgt_ff[1]);
  wire wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire wr_cmd = wr_fire & (aw_addr_ff == `OFS_CMD);
  wire [CODE_W-1:0] cmd_code = w_data_ff[CODE_W-1:0];
  wire sel_multi = w_data_ff[`CMD_SEL_MULTI];
  wire sel_single = w_data_ff[`CMD_SEL_SINGLE];
  // RULE3: reject single part
  wire cmd_reject = wr_cmd & sel_single & single_dis_ff;
  wire fault = oc_tot_det | ov_det | (uv_det & ~prot_mask);

  function [CODE_W-1:0] step_toward;
    input [CODE_W-1:0] cur;
    input [CODE_W-1:0] tgt;
    begin
      if (tgt > cur) begin
        step_toward = cur + {{(CODE_W-1){1'b0}}, 1'b1};
      end else begin
        step_toward = cur - {{(CODE_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  function [2:0] count_ones;
    input [5:0] v;
    integer i;
    begin
      count_ones = 3'h0;
      for (i = 0; i < 6; i = i + 1) begin
        count_ones = count_ones + {2'h0, v[i]};
      end
    end
  endfunction

  // Straps are caught on the first edge after reset release.
  always @(posedge mclk) begin
    if (sys_rst) begin
      strap_done_ff <= 1'b0;
      phase_en_ff   <= 6'h3F;
      single_dis_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      // RULE1: lowest three always kept
      phase_en_ff   <= ~phase_strap | 6'h07;
      // RULE2: single section disabled
      single_dis_ff <= single_strap;
    end
  end

  always @(posedge mclk) begin
    for (s = 0; s < 2; s = s + 1) begin
      if (sys_rst) begin
        ref_ff[s]  <= {CODE_W{1'b0}};
        tgt_ff[s]  <= {CODE_W{1'b0}};
        tick_ff[s] <= 8'h00;
        fast_ff[s] <= 1'b0;
      end else begin
        // RULE4: accept new target
        // RULE5: retarget while ramping
        if (wr_cmd && ((s == 0 && sel_multi) ||
            (s == 1 && sel_single && !single_dis_ff))) begin
          tgt_ff[s]  <= cmd_code;
          fast_ff[s] <= w_data_ff[`CMD_FAST];
        end
        if (ref_ff[s] == tgt_ff[s]) begin
          tick_ff[s] <= 8'h00;
        end else if (tick_ff[s] == 8'h00) begin
          // RULE14: one code per tick
          ref_ff[s]  <= step_toward(ref_ff[s], tgt_ff[s]);
          // RULE6: tick spacing per rate
          tick_ff[s] <= fast_ff[s] ? FAST_T - 8'h01 : SLOW_T - 8'h01;
        end else begin
          tick_ff[s] <= tick_ff[s] - 8'h01;
        end
      end
    end
  end

  // Re-arm delay runs from the end of the transition.
  always @(posedge mclk) begin
    if (sys_rst) begin
      rearm_ff  <= 9'h000;
      prot_mask <= 1'b0;
      busy_d_ff <= 1'b0;
    end else begin
      busy_d_ff <= busy;
      // RULE7: mask then delayed re-arm
      if (busy) begin
        rearm_ff  <= REARM_T;
        prot_mask <= 1'b1;
      end else if (rearm_ff != 9'h000) begin
        rearm_ff  <= rearm_ff - 9'h001;
      end else begin
        prot_mask <= 1'b0;
      end
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: begin
        if (ctrl_ff[`CTRL_EN] && tgt_ff[0] != {CODE_W{1'b0}}) begin
          nxt_state = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (first_pulse) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tgt_ff[0] == {CODE_W{1'b0}} && ref_ff[0] == {CODE_W{1'b0}}) begin
          nxt_state = ST_OFF;
        end
      end
      ST_LATCH: nxt_state = ST_LATCH;
      default: nxt_state = ST_OFF;
    endcase
    if (state_ff != ST_LATCH && state_ff != ST_OFF) begin
      if (!ctrl_ff[`CTRL_EN]) begin
        nxt_state = ST_OFF;
      end
      // RULE8: total overcurrent latches
      if (fault) begin
        nxt_state = ST_LATCH;
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_ff               <= ST_OFF;
      ov_latch_ff            <= 1'b0;
      phase_pwm_out          <= 6'h00;
      phase_pwm_oe           <= 6'h00;
      single_section_pwm_out <= 1'b0;
      single_section_pwm_oe  <= 1'b0;
      driver_enable_out      <= 1'b0;
      ov_thresh_sel          <= `OVTH_NORM;
      droop_quarter          <= 1'b0;
      ref_multi              <= {CODE_W{1'b0}};
      ref_single             <= {CODE_W{1'b0}};
    end else begin
      state_ff   <= nxt_state;
      ref_multi  <= ref_ff[0];
      ref_single <= ref_ff[1];
      if (nxt_state == ST_LATCH && state_ff != ST_LATCH) begin
        ov_latch_ff <= ov_det & ~oc_tot_det;
      end
      // RULE12: quarter droop gain
      droop_quarter <= ctrl_ff[`CTRL_DDR] & ctrl_ff[`CTRL_DROOP];
      // RULE13: raised threshold in transition
      if (busy || prot_mask) begin
        ov_thresh_sel <= ctrl_ff[`CTRL_OFFSET] ? `OVTH_2V4 : `OVTH_1V8;
      end else begin
        ov_thresh_sel <= `OVTH_NORM;
      end
      phase_pwm_out          <= 6'h00;
      single_section_pwm_out <= 1'b0;
      single_section_pwm_oe  <= 1'b0;
      case (nxt_state)
        ST_SOFT: begin
          // RULE9: high impedance, driver off
          // RULE11: protection low side on
          phase_pwm_oe      <= ov_det ? phase_en_ff : 6'h00;
          driver_enable_out <= ov_det;
        end
        ST_RUN: begin
          // RULE10: switching with driver on
          phase_pwm_out          <= pwm_req & phase_en_ff;
          phase_pwm_oe           <= phase_en_ff;
          single_section_pwm_out <= single_section_pwm_out_req & ~single_dis_ff;
          single_section_pwm_oe  <= ~single_dis_ff;
          driver_enable_out      <= 1'b1;
        end
        ST_LATCH: begin
          // RULE11: low side held on after overvoltage
          phase_pwm_oe      <= (ov_latch_ff || (state_ff != ST_LATCH &&
                                ov_det && !oc_tot_det)) ? phase_en_ff : 6'h00;
          driver_enable_out <= ov_latch_ff || (state_ff != ST_LATCH &&
                                ov_det && !oc_tot_det);
        end
        default: begin
          phase_pwm_oe      <= 6'h00;
          driver_enable_out <= 1'b0;
        end
      endcase
    end
  end

  // A write-one clear never hides an event of the same cycle.
  always @* begin
    irq_set = 4'h0;
    irq_set[`IRQ_DONE]   = busy_d_ff & ~busy;
    irq_set[`IRQ_REJECT] = cmd_reject;
    irq_set[`IRQ_FAULT]  = (nxt_state == ST_LATCH) & (state_ff != ST_LATCH);
    irq_set[`IRQ_UV]     = uv_det & ~prot_mask;
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 6'h00;
      w_data_ff     <= 32'h00000000;
      w_strb_ff     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      ctrl_ff       <= `CTRL_RST;
      irq_mask_ff   <= 4'h0;
      irq_stat_ff   <= 4'h0;
      irq           <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_got_ff && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_got_ff     <= 1'b1;
        aw_addr_ff    <= {s_axi_awaddr[5:2], 2'h0};
      end
      if (s_axi_wvalid && !w_got_ff && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_got_ff     <= 1'b1;
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      irq_stat_ff <= irq_stat_ff | irq_set;
      if (wr_fire) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr_ff)
          `OFS_CTRL: if (w_strb_ff[0]) ctrl_ff <= w_data_ff[3:0];
          `OFS_IRQ_MASK: if (w_strb_ff[0]) irq_mask_ff <= w_data_ff[3:0];
          `OFS_IRQ_STAT: begin
            if (w_strb_ff[0]) begin
              irq_stat_ff <= (irq_stat_ff & ~w_data_ff[3:0]) | irq_set;
            end
          end
          `OFS_CMD, `OFS_STATUS, `OFS_STRAP, `OFS_REF: begin
          end
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  always @* begin
    nxt_rmapped = 1'b1;
    nxt_rdata   = 32'h00000000;
    case ({s_axi_araddr[5:2], 2'h0})
      `OFS_CTRL:     nxt_rdata[3:0] = ctrl_ff;
      `OFS_CMD:      nxt_rdata = {21'h000000, fast_ff[0], 2'h0, tgt_ff[0]};
      `OFS_STATUS:   nxt_rdata = {22'h000000, ov_latch_ff, prot_mask,
                                  state_ff, 2'h0, ref_ff[1] != tgt_ff[1],
                                  ref_ff[0] != tgt_ff[0]};
      `OFS_IRQ_STAT: nxt_rdata[3:0] = irq_stat_ff;
      `OFS_IRQ_MASK: nxt_rdata[3:0] = irq_mask_ff;
      `OFS_STRAP:    nxt_rdata = {22'h000000, count_ones(phase_en_ff),
                                  single_dis_ff, phase_en_ff};
      `OFS_REF:      nxt_rdata = {tgt_ff[1], tgt_ff[0], ref_ff[1], ref_ff[0]};
      default:       nxt_rmapped = 1'b0;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= nxt_rdata;
        s_axi_rresp   <= nxt_rmapped ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

endmodule

// >>> hw/dvt_seq_defs.vh
`ifndef DVT_SEQ_DEFS_VH
`define DVT_SEQ_DEFS_VH

`define CLK_MHZ          125
`define STEP_MV          5
`define FAST_MV_PER_US   20
`define SLOW_MV_PER_US   5
// Longest tick interval so the average slope is never below the rate.
`define FAST_TICKS       ((`STEP_MV * `CLK_MHZ) / `FAST_MV_PER_US)
`define SLOW_TICKS       ((`STEP_MV * `CLK_MHZ) / `SLOW_MV_PER_US)
`define REARM_NS         2000
`define REARM_TICKS      ((`REARM_NS * `CLK_MHZ + 999) / 1000)

`define OFS_CTRL         6'h00
`define OFS_CMD          6'h04
`define OFS_STATUS       6'h08
`define OFS_IRQ_STAT     6'h0C
`define OFS_IRQ_MASK     6'h10
`define OFS_STRAP        6'h14
`define OFS_REF          6'h18

`define CTRL_EN          0
`define CTRL_DDR         1
`define CTRL_DROOP       2
`define CTRL_OFFSET      3
`define CTRL_RST         4'h0

`define CMD_SEL_MULTI    8
`define CMD_SEL_SINGLE   9
`define CMD_FAST         10

`define IRQ_DONE         0
`define IRQ_REJECT       1
`define IRQ_FAULT        2
`define IRQ_UV           3

`define OVTH_NORM        2'h0
`define OVTH_1V8         2'h1
`define OVTH_2V4         2'h2

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// >>> tb/dvt_seq_assertions.sv
`timescale 1ns/1ps
module dvt_seq_assertions #(
  parameter CODE_W = 8
) (
  input wire              mclk,
  input wire              sys_rst,
  input wire [5:0]        phase_strap,
  input wire              single_strap,
  input wire              first_pulse,
  input wire              ov_det,
  input wire              oc_tot_det,
  input wire [5:0]        phase_pwm_oe,
  input wire              single_section_pwm_oe,
  input wire              driver_enable_out,
  input wire [1:0]        ov_thresh_sel,
  input wire              prot_mask,
  input wire [CODE_W-1:0] ref_multi
);
  // Saturates so that a long idle stretch never wraps back into a window.
  reg [7:0] quiet_ff;
  always @(posedge mclk) begin
    if (sys_rst)
      quiet_ff <= 8'hFF;
    else if ($changed(ref_multi))
      quiet_ff <= 8'h00;
    else if (quiet_ff != 8'hFF)
      quiet_ff <= quiet_ff + 8'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_drv_cause: assert property ($rose(driver_enable_out) |->
    $past(first_pulse) || $past(ov_det)) else $error("driver on uncaused");
  a_hiz_idle: assert property (!driver_enable_out |->
    phase_pwm_oe == 6'h00 && !single_section_pwm_oe) else $error("pin driven");
  a_oc_latch: assert property (oc_tot_det |=>
    !driver_enable_out && phase_pwm_oe == 6'h00) else $error("no oc latch");
  a_strap_phase: assert property (
    (phase_pwm_oe & phase_strap & 6'h38) == 6'h00) else $error("strap phase on");
  a_single_off: assert property (single_strap |->
    !single_section_pwm_oe) else $error("single section on");
  a_mask_hold: assert property (quiet_ff < 8'hC8 && driver_enable_out
    |-> prot_mask) else $error("mask dropped early");
  a_step_unit: assert property ($changed(ref_multi) |->
    ref_multi == $past(ref_multi) + 1'b1 || $past(ref_multi) == ref_multi + 1'b1)
    else $error("step not one code");
  a_step_gap: assert property ($changed(ref_multi) |=>
    $stable(ref_multi) [*8]) else $error("steps too close");
  a_ov_raise: assert property ($changed(ref_multi) |->
    $past(ov_thresh_sel) != 2'h0) else $error("ov level not raised");
  c_run: cover property ($rose(driver_enable_out));
  c_step: cover property ($changed(ref_multi));
  c_rearm: cover property ($fell(prot_mask));
endmodule
bind dvt_seq dvt_seq_assertions #(.CODE_W(CODE_W)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .phase_strap(phase_strap),
  .single_strap(single_strap), .first_pulse(first_pulse), .ov_det(ov_det),
  .oc_tot_det(oc_tot_det), .phase_pwm_oe(phase_pwm_oe),
  .single_section_pwm_oe(single_section_pwm_oe),
  .driver_enable_out(driver_enable_out), .ov_thresh_sel(ov_thresh_sel),
  .prot_mask(prot_mask), .ref_multi(ref_multi));

// >>> tb/dvt_gate_drv.sv
`timescale 1ns/1ps
module dvt_gate_drv (
  input  wire [5:0] pwm,
  input  wire [5:0] oe,
  input  wire       en,
  output wire [5:0] hs_on,
  output wire [5:0] ls_on
);
  // A released input floats mid-level, so neither switch fires.
  assign hs_on = {6{en}} & oe & pwm;
  // Low side conducts only with the driver enabled.
  assign ls_on = {6{en}} & oe & ~pwm;
endmodule

// >>> tb/dvt_seq_tb_top.sv
`timescale 1ns/1ps
`include "dvt_seq_defs.vh"
module dvt_seq_tb_top;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         first_pulse = 1'b0;
  reg  [5:0]  pwm_req = 6'h00;
  reg         single_section_pwm_out_req = 1'b0;
  reg         ov_det = 1'b0;
  reg         uv_det = 1'b0;
  reg         oc_tot_det = 1'b0;
  reg  [5:0]  awaddr = 6'h00;
  reg  [5:0]  araddr = 6'h00;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg  [7:0]  lfsr = 8'h35;
  reg  [65:0] re;
  reg  [65:0] rq[$];
  reg  [1:0]  wq[$];
  integer     mismatches = 0;
  integer     check_count = 0;
  integer     i;
  wire [5:0]  pwm_out, pwm_oe, hs_on, ls_on;
  wire        sp_out, sp_oe, drv_en, prot_mask, droop_q, irq;
  wire [1:0]  ov_sel, bresp, rresp;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [31:0] rdata;
  wire [7:0]  ref_m, ref_s;
  always #4 mclk = ~mclk;
  dvt_seq dut (
    .mclk(mclk), .sys_rst(sys_rst), .phase_strap(6'h38), .single_strap(1'b1),
    .first_pulse(first_pulse), .pwm_req(pwm_req), .single_section_pwm_out_req(single_section_pwm_out_req),
    .ov_det(ov_det), .uv_det(uv_det), .oc_tot_det(oc_tot_det),
    .phase_pwm_out(pwm_out), .phase_pwm_oe(pwm_oe),
    .single_section_pwm_out(sp_out), .single_section_pwm_oe(sp_oe),
    .driver_enable_out(drv_en), .ov_thresh_sel(ov_sel),
    .prot_mask(prot_mask), .droop_quarter(droop_q), .ref_multi(ref_m),
    .ref_single(ref_s), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  dvt_gate_drv drv (.pwm(pwm_out), .oe(pwm_oe), .en(drv_en),
    .hs_on(hs_on), .ls_on(ls_on));
  function [7:0] nx(input [7:0] s);
    nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task hang(input integer n);
    if (n >= 2000) begin
      chk("wait bound", 0, n);
      complete_run;
    end
  endtask
  task settle;
    begin
      repeat (2) @(posedge mclk);
      #1;
    end
  endtask
  task rst_seq;
    begin
      @(posedge mclk);
      sys_rst <= 1'b1;
      ov_det <= 1'b0;
      oc_tot_det <= 1'b0;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  task wr(input [5:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      wq.push_back(r);
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
        @(posedge mclk);
        n = n + 1;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 2000);
      bready <= 1'b0;
      hang(n);
    end
  endtask
  task rd(input [5:0] a, input [31:0] e, input [31:0] m, input [1:0] r);
    integer n;
    begin
      rq.push_back({r, m, e});
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
        @(posedge mclk);
        n = n + 1;
        if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 2000);
      rready <= 1'b0;
      hang(n);
    end
  endtask
  task wait_ref(input [7:0] v, output integer n);
    begin
      n = 0;
      while (ref_m !== v && n < 2000) begin
        @(posedge mclk);
        n = n + 1;
      end
      hang(n);
    end
  endtask
  task gap(input [7:0] v, input integer e);
    integer n;
    begin
      wait_ref(v, n);
      wait_ref(v + 8'h01, n);
      chk("step gap", e, n);
    end
  endtask
  // Results are compared here, in the order the requests were issued.
  always @(posedge mclk) begin
    if (rvalid && rready) begin
      re = rq.pop_front();
      chk("rdata", re[31:0], rdata & re[63:32]);
      chk("rresp", {30'h0, re[65:64]}, {30'h0, rresp});
    end
    if (bvalid && bready)
      chk("bresp", {30'h0, wq.pop_front()}, {30'h0, bresp});
  end
  initial begin
    rst_seq;
    rd(`OFS_CTRL, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`OFS_STRAP, 32'h1C7, 32'h3FF, `RESP_OKAY);
    rd(6'h3C, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
    wr(6'h3C, 32'h0, `RESP_SLVERR);
    wr(`OFS_CTRL, 32'h6, `RESP_OKAY);
    settle;
    chk("droop", 1, droop_q);
    wr(`OFS_CTRL, 32'h2, `RESP_OKAY);
    settle;
    chk("droop", 0, droop_q);
    $display("test config done");
    for (i = 3; i > 0; i = i - 2) begin
      wr(`OFS_IRQ_MASK, i, `RESP_OKAY);
      wr(`OFS_CMD, 32'h210, `RESP_OKAY);
      settle;
      chk("irq", i >> 1, irq);
      chk("ref single", 0, ref_s);
      rd(`OFS_IRQ_STAT, 32'h2, 32'h2, `RESP_OKAY);
      wr(`OFS_IRQ_STAT, 32'h2, `RESP_OKAY);
      settle;
      chk("irq clear", 0, irq);
    end
    $display("test reject done");
    wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
    wr(`OFS_CMD, 32'h510, `RESP_OKAY);
    settle;
    chk("soft oe", 0, {drv_en, pwm_oe, ls_on});
    gap(8'h01, `FAST_TICKS);
    @(posedge mclk) first_pulse <= 1'b1;
    @(posedge mclk) first_pulse <= 1'b0;
    settle;
    chk("run oe", 7'h47, {drv_en, pwm_oe});
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge mclk);
      lfsr = nx(lfsr);
      pwm_req <= lfsr[5:0];
      single_section_pwm_out_req <= lfsr[6];
      settle;
      chk("pwm", lfsr[2:0], pwm_out[2:0]);
      chk("low side", {29'h0, ~lfsr[2:0]}, {29'h0, ls_on[2:0]});
      chk("high side", lfsr[2:0], hs_on[2:0]);
      chk("single pwm", 0, {sp_out, sp_oe});
    end
    wr(`OFS_CMD, 32'h101, `RESP_OKAY);
    wait_ref(8'h01, i);
    repeat (200) @(posedge mclk);
    chk("retarget", 1, ref_m);
    wr(`OFS_CMD, 32'h103, `RESP_OKAY);
    gap(8'h02, `SLOW_TICKS);
    @(posedge mclk) uv_det <= 1'b1;
    settle;
    chk("uv masked", 1, drv_en);
    chk("ov level", `OVTH_1V8, ov_sel);
    @(posedge mclk) uv_det <= 1'b0;
    repeat (300) @(posedge mclk);
    #1;
    chk("rearm", 0, prot_mask);
    @(posedge mclk) uv_det <= 1'b1;
    settle;
    @(posedge mclk) uv_det <= 1'b0;
    chk("uv latch", 0, {drv_en, pwm_oe});
    $display("test ramp done");
    rst_seq;
    wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
    wr(`OFS_CMD, 32'h510, `RESP_OKAY);
    wait_ref(8'h02, i);
    @(posedge mclk) oc_tot_det <= 1'b1;
    settle;
    chk("oc latch", 0, {drv_en, pwm_oe});
    rd(`OFS_STATUS, 32'h80, 32'hF0, `RESP_OKAY);
    $display("test overcurrent done");
    rst_seq;
    wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
    wr(`OFS_CMD, 32'h501, `RESP_OKAY);
    repeat (400) @(posedge mclk);
    ov_det <= 1'b1;
    settle;
    chk("ov low side", 10'h3C7, {drv_en, pwm_oe[2:0], pwm_out[2:0],
      ls_on[2:0]});
    $display("test overvoltage done");
    complete_run;
  end
endmodule
